// File: bench/mdu_link_asserts.sv
`timescale 1ns/1ps
module mdu_link_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic we,
    input wire logic wide,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic div_busy,
    input wire logic b_zero
);
    logic [5:0] busy_cnt;
    // Cycles spent dividing
    always_ff @(posedge aclk) begin
        if (!aresetn || !div_busy) begin
            busy_cnt <= 6'h00;
        end else begin
            busy_cnt <= busy_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_start_req;
        req && we && (addr == mdu_pkg::IDX_CTRL) && wdata[mdu_pkg::CTRL_START] && wdata[mdu_pkg::CTRL_DIV] && !div_busy;
    endsequence
    sequence s_busy_run;
        div_busy [*8];
    endsequence
    property p_ack_after_req;
        req |=> ack;
    endproperty
    a_ack_after_req: assert property (p_ack_after_req) else $error("ack missing after req");
    property p_ack_cause;
        ack |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
    property p_start_go;
        s_start_req |=> s_busy_run;
    endproperty
    a_start_go: assert property (p_start_go) else $error("division did not start");
    property p_start_cause;
        $rose(div_busy) |-> $past(req && we && addr == mdu_pkg::IDX_CTRL && wdata[mdu_pkg::CTRL_START]);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("division started by itself");
    property p_div_len;
        $fell(div_busy) |-> busy_cnt == 6'h20;
    endproperty
    a_div_len: assert property (p_div_len) else $error("division length wrong");
    property p_div_max;
        div_busy |-> busy_cnt < 6'h20;
    endproperty
    a_div_max: assert property (p_div_max) else $error("division runs too long");
    property p_ctrl_read;
        req && !we && addr == mdu_pkg::IDX_CTRL |=>
            rdata[mdu_pkg::CTRL_START] == $past(div_busy) && rdata[15:8] == 8'h00 && rdata[5:4] == 2'h0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");
    property p_rdata_hold;
        !(req && !we) |=> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");
    property p_bzero_reset;
        $rose(aresetn) |-> b_zero;
    endproperty
    a_bzero_reset: assert property (p_bzero_reset) else $error("divisor not clear");
    property p_wide_data;
        req && we && addr != mdu_pkg::IDX_CTRL |-> wide;
    endproperty
    a_wide_data: assert property (p_wide_data) else $error("data write not 16-bit");
endmodule

// File: bench/mul_div_mac_unit_test.sv
`timescale 1ns/1ps
module mul_div_mac_unit_test;
    logic aclk;
    logic aresetn;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_fail = 0;
    int compares = 0;
    mdu_if link (.aclk(aclk), .aresetn(aresetn));
    mdu_device u_mdu_device (.link(link));
    mdu_host #(.ADDR_W(8)) u_mdu_host (.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .link(link));
    mdu_link_asserts u_mdu_link_asserts (.aclk(link.aclk), .aresetn(link.aresetn), .req(link.req),
        .we(link.we), .wide(link.wide), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack), .div_busy(link.div_busy), .b_zero(link.b_zero));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, {16'hA5A5, d}, 4'hF, r);
        check({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic test_reset;
        for (int o = 0; o <= 24; o += 4) rd(8'(o), 32'h0, mdu_pkg::RESP_OKAY);
    endtask
    task automatic test_mul;
        wr(mdu_pkg::OFF_CTRL, 16'h0000, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_HIGH, 16'hFFFF, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'hFFFF, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'h0001, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_HIGH, 32'hFFFE, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_CTRL, 16'h0008, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'h0003, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_HIGH, 16'hFFFF, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'hFFFD, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_HIGH, 32'hFFFF, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'h0002, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'hFFFD, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_HIGH, 16'h0002, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'h0004, mdu_pkg::RESP_OKAY);
    endtask
    task automatic test_mac;
        wr(mdu_pkg::OFF_CTRL, 16'h0040, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_C_LOW, 16'hFFF0, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_C_HIGH, 16'hFFFF, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'h0010, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_HIGH, 16'h0002, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'h0020, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_LOW, 32'h0010, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_HIGH, 32'h0000, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_CTRL, 32'h0044, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_CTRL, 16'h0048, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_C_LOW, 16'h0005, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_C_HIGH, 16'h0000, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'h0004, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_HIGH, 16'hFFFE, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_LOW, 32'hFFFD, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_HIGH, 32'hFFFF, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_CTRL, 32'h004A, mdu_pkg::RESP_OKAY);
    endtask
    task automatic test_refuse;
        logic [1:0] r;
        axi_write(mdu_pkg::OFF_A_LOW, 32'h1234, 4'h1, r);
        check({30'h0, r}, {30'h0, mdu_pkg::RESP_SLVERR});
        rd(mdu_pkg::OFF_A_LOW, 32'h0004, mdu_pkg::RESP_OKAY);
        wr(8'h1C, 16'h1111, mdu_pkg::RESP_SLVERR);
        rd(8'h1C, 32'h0, mdu_pkg::RESP_SLVERR);
        wr(8'h02, 16'h1111, mdu_pkg::RESP_SLVERR);
        wr(mdu_pkg::OFF_CTRL, 16'h0001, mdu_pkg::RESP_SLVERR);
        rd(mdu_pkg::OFF_CTRL, 32'h004A, mdu_pkg::RESP_OKAY);
    endtask
    task automatic test_div;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(mdu_pkg::OFF_CTRL, 16'h0080, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_B_HIGH, 16'h0000, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_B_LOW, 16'h0000, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_CTRL, 16'h0081, mdu_pkg::RESP_SLVERR);
        wr(mdu_pkg::OFF_A_HIGH, 16'h0001, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_A_LOW, 16'h2345, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_B_LOW, 16'h0100, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_CTRL, 16'h0081, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_A_LOW, 32'h0, mdu_pkg::RESP_SLVERR);
        wr(mdu_pkg::OFF_A_LOW, 16'h0000, mdu_pkg::RESP_SLVERR);
        wr(mdu_pkg::OFF_B_LOW, 16'h0001, mdu_pkg::RESP_SLVERR);
        rd(mdu_pkg::OFF_CTRL, 32'h0083, mdu_pkg::RESP_OKAY);
        n = 0;
        do begin
            axi_read(mdu_pkg::OFF_CTRL, d, r);
            n++;
        end while (d[0] === 1'b1 && n < 20);
        check(d, 32'h0082);
        rd(mdu_pkg::OFF_A_HIGH, 32'h0000, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_A_LOW, 32'h0123, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_LOW, 32'h0045, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_C_HIGH, 32'h0000, mdu_pkg::RESP_OKAY);
        rd(mdu_pkg::OFF_B_LOW, 32'h0100, mdu_pkg::RESP_OKAY);
        wr(mdu_pkg::OFF_CTRL, 16'h0081, mdu_pkg::RESP_OKAY);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        finish_test();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_mul();
        test_mac();
        test_refuse();
        test_div();
        do_reset();
        test_reset();
        finish_test();
    end
endmodule

// File: logic/mdu_device.sv
`timescale 1ns/1ps
// Functional notes
// - 16x16 multiply, unsigned or signed
// - Accumulate product into 32-bit value
// - Unsigned 32 by 32 division
// - A high is multiplier, A low multiplicand
// - A pair holds dividend, then quotient
// - B pair receives the product
// - B pair holds the divisor
// - Data registers clear on reset
// - Data registers written as 16-bit units
// - No A writes during division
// - A reads invalid during division
// - Signed modes use two's complement
// - No B writes during division
// - Never divide by zero
// - Start flag starts division, self-clears
// - Multiply starts after both A writes
// - C pair: accumulator or remainder
// - 8-bit control selects the mode
module mdu_device (
    mdu_if.device link
);
    logic [15:0] a_low_reg;
    logic [15:0] a_high_reg;
    logic [15:0] b_low_reg;
    logic [15:0] b_high_reg;
    logic [15:0] c_low_reg;
    logic [15:0] c_high_reg;
    logic div_sel_reg;
    logic acc_sel_reg;
    logic sgn_sel_reg;
    logic ovf_reg;
    logic neg_reg;
    logic start_reg;
    logic got_lo_reg;
    logic got_hi_reg;
    logic [5:0] step_reg;
    logic [15:0] rdata_reg;
    logic ack_reg;
    logic b_zero_reg;

    logic wr;
    logic wr_data;
    logic wr_ctrl;
    logic mul_go;
    logic start_go;
    logic div_last;
    logic mac_ovf;
    logic ge;
    logic [31:0] prod;
    logic [31:0] sum;
    logic [32:0] sum_c;
    logic [32:0] rem_sh;
    logic [33:0] diff;

    localparam int STEP_W = mdu_pkg::STEP_W;

    function automatic logic hit(input logic en, input logic [2:0] a, input logic [2:0] idx);
        return en && (a == idx);
    endfunction

    function automatic logic [31:0] mul16(input logic [15:0] x, input logic [15:0] y, input logic sgn);
        logic [31:0] xs;
        logic [31:0] ys;
        xs = sgn ? {{16{x[15]}}, x} : {16'h0000, x};
        ys = sgn ? {{16{y[15]}}, y} : {16'h0000, y};
        return xs * ys;
    endfunction

    assign wr = link.req && link.we;
    // data writes need a 16-bit access
    assign wr_data = wr && link.wide;
    assign wr_ctrl = hit(wr, link.addr, mdu_pkg::IDX_CTRL);
    assign mul_go = got_lo_reg && got_hi_reg && !div_sel_reg;
    assign start_go = wr_ctrl && link.wdata[mdu_pkg::CTRL_START] && link.wdata[mdu_pkg::CTRL_DIV]
        && !start_reg;
    assign div_last = start_reg && (step_reg == STEP_W'(mdu_pkg::DIV_STEPS - 1));

    always_comb begin
        prod = mul16(a_high_reg, a_low_reg, sgn_sel_reg);
        sum_c = {1'b0, c_high_reg, c_low_reg} + {1'b0, prod};
        sum = sum_c[31:0];
        if (sgn_sel_reg) begin
            mac_ovf = (c_high_reg[15] == prod[31]) && (sum[31] != c_high_reg[15]);
        end else begin
            mac_ovf = sum_c[32];
        end
        rem_sh = {c_high_reg, c_low_reg, a_high_reg[15]};
        diff = {1'b0, rem_sh} - {2'b00, b_high_reg, b_low_reg};
        ge = !diff[33];
    end

    // dividend shifts out, quotient shifts in
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            a_low_reg <= mdu_pkg::DATA_RESET;
            a_high_reg <= mdu_pkg::DATA_RESET;
        end else if (start_reg) begin
            a_high_reg <= {a_high_reg[14:0], a_low_reg[15]};
            a_low_reg <= {a_low_reg[14:0], ge};
        end else begin
            if (hit(wr_data, link.addr, mdu_pkg::IDX_A_LOW)) begin
                a_low_reg <= link.wdata;
            end
            if (hit(wr_data, link.addr, mdu_pkg::IDX_A_HIGH)) begin
                a_high_reg <= link.wdata;
            end
        end
    end

    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            b_low_reg <= mdu_pkg::DATA_RESET;
            b_high_reg <= mdu_pkg::DATA_RESET;
        end else if (mul_go) begin
            b_high_reg <= prod[31:16];
            b_low_reg <= prod[15:0];
        end else begin
            if (hit(wr_data, link.addr, mdu_pkg::IDX_B_LOW)) begin
                b_low_reg <= link.wdata;
            end
            if (hit(wr_data, link.addr, mdu_pkg::IDX_B_HIGH)) begin
                b_high_reg <= link.wdata;
            end
        end
    end

    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            c_low_reg <= mdu_pkg::DATA_RESET;
            c_high_reg <= mdu_pkg::DATA_RESET;
        end else if (start_go) begin
            c_low_reg <= mdu_pkg::DATA_RESET;
            c_high_reg <= mdu_pkg::DATA_RESET;
        end else if (start_reg) begin
            c_high_reg <= ge ? diff[31:16] : rem_sh[31:16];
            c_low_reg <= ge ? diff[15:0] : rem_sh[15:0];
        end else if (mul_go && acc_sel_reg) begin
            c_high_reg <= sum[31:16];
            c_low_reg <= sum[15:0];
        end else begin
            if (hit(wr_data, link.addr, mdu_pkg::IDX_C_LOW)) begin
                c_low_reg <= link.wdata;
            end
            if (hit(wr_data, link.addr, mdu_pkg::IDX_C_HIGH)) begin
                c_high_reg <= link.wdata;
            end
        end
    end

    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            div_sel_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_DIV];
            acc_sel_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_ACC];
            sgn_sel_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_SGN];
        end else if (wr_ctrl && !start_reg) begin
            div_sel_reg <= link.wdata[mdu_pkg::CTRL_DIV];
            acc_sel_reg <= link.wdata[mdu_pkg::CTRL_ACC];
            sgn_sel_reg <= link.wdata[mdu_pkg::CTRL_SGN];
        end
    end

    // flag clears with the last step
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            start_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_START];
            step_reg <= '0;
        end else if (start_go) begin
            start_reg <= 1'b1;
            step_reg <= '0;
        end else if (start_reg) begin
            start_reg <= !div_last;
            step_reg <= step_reg + 6'h01;
        end
    end

    // Overflow sticky, set wins over clear
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            ovf_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_OVF];
            neg_reg <= mdu_pkg::CTRL_RESET[mdu_pkg::CTRL_NEG];
        end else if (mul_go && acc_sel_reg) begin
            ovf_reg <= mac_ovf || (ovf_reg && !(wr_ctrl && !link.wdata[mdu_pkg::CTRL_OVF]));
            neg_reg <= sgn_sel_reg && sum[31];
        end else if (wr_ctrl && !link.wdata[mdu_pkg::CTRL_OVF]) begin
            ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            got_lo_reg <= 1'b0;
            got_hi_reg <= 1'b0;
        end else begin
            if (hit(wr_data, link.addr, mdu_pkg::IDX_A_LOW)) begin
                got_lo_reg <= 1'b1;
            end else if (mul_go || div_sel_reg) begin
                got_lo_reg <= 1'b0;
            end
            if (hit(wr_data, link.addr, mdu_pkg::IDX_A_HIGH)) begin
                got_hi_reg <= 1'b1;
            end else if (mul_go || div_sel_reg) begin
                got_hi_reg <= 1'b0;
            end
        end
    end

    // Read port and acknowledge
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            ack_reg <= 1'b0;
            rdata_reg <= mdu_pkg::DATA_RESET;
            b_zero_reg <= 1'b1;
        end else begin
            ack_reg <= link.req;
            b_zero_reg <= ({b_high_reg, b_low_reg} == 32'h00000000);
            if (link.req && !link.we) begin
                unique case (link.addr)
                    mdu_pkg::IDX_A_LOW: rdata_reg <= a_low_reg;
                    mdu_pkg::IDX_A_HIGH: rdata_reg <= a_high_reg;
                    mdu_pkg::IDX_B_LOW: rdata_reg <= b_low_reg;
                    mdu_pkg::IDX_B_HIGH: rdata_reg <= b_high_reg;
                    mdu_pkg::IDX_C_LOW: rdata_reg <= c_low_reg;
                    mdu_pkg::IDX_C_HIGH: rdata_reg <= c_high_reg;
                    mdu_pkg::IDX_CTRL: rdata_reg <= {8'h00, div_sel_reg, acc_sel_reg, 2'b00,
                        sgn_sel_reg, ovf_reg, neg_reg, start_reg};
                    default: rdata_reg <= mdu_pkg::DATA_RESET;
                endcase
            end
        end
    end

    assign link.rdata = rdata_reg;
    assign link.ack = ack_reg;
    assign link.div_busy = start_reg;
    assign link.b_zero = b_zero_reg;
endmodule

// File: logic/mdu_host.sv
`timescale 1ns/1ps
module mdu_host #(
    parameter int ADDR_W = 8
) (
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    mdu_if.host link
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WR = 5'b00010,
        ST_RD = 5'b00100,
        ST_BR = 5'b01000,
        ST_RR = 5'b10000
    } state_e;

    if (ADDR_W < mdu_pkg::MIN_ADDR_W) begin : g_bad_width
        $error("ADDR_W too small");
    end

    state_e state_reg;
    logic aw_held_reg, w_held_reg, ar_held_reg;
    logic awready_reg, wready_reg, arready_reg;
    logic [ADDR_W-1:0] awaddr_reg, araddr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic req_reg, we_reg, wide_reg;
    logic [2:0] addr_reg;
    logic [15:0] dwdata_reg;

    logic [2:0] w_idx, r_idx;
    logic w_ok, r_ok, go_rd, err_rd, go_wr, err_wr, idle;

    always_comb begin
        w_idx = mdu_pkg::off_to_idx(awaddr_reg[7:0]);
        r_idx = mdu_pkg::off_to_idx(araddr_reg[7:0]);
        w_ok = mdu_pkg::off_valid(awaddr_reg[7:0]) && ((awaddr_reg >> 8) == '0);
        if (w_idx == mdu_pkg::IDX_CTRL) begin
            w_ok = w_ok && wstrb_reg[0] && !(wdata_reg[mdu_pkg::CTRL_START]
                && (!wdata_reg[mdu_pkg::CTRL_DIV] || link.b_zero));
        end else begin
            w_ok = w_ok && (wstrb_reg == 2'b11) && !link.div_busy;
        end
        // no A or C reads while dividing
        r_ok = mdu_pkg::off_valid(araddr_reg[7:0]) && ((araddr_reg >> 8) == '0)
            && !(link.div_busy && r_idx != mdu_pkg::IDX_B_LOW && r_idx != mdu_pkg::IDX_B_HIGH
            && r_idx != mdu_pkg::IDX_CTRL);
        idle = (state_reg == ST_IDLE);
        go_rd = idle && ar_held_reg && r_ok;
        err_rd = idle && ar_held_reg && !r_ok;
        go_wr = idle && !ar_held_reg && aw_held_reg && w_held_reg && w_ok;
        err_wr = idle && !ar_held_reg && aw_held_reg && w_held_reg && !w_ok;
    end

    // Address and data capture
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            ar_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
            awaddr_reg <= '0;
            araddr_reg <= '0;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'b00;
        end else begin
            if (awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= awaddr;
            end else if (bvalid_reg && bready) begin
                aw_held_reg <= 1'b0;
                awready_reg <= 1'b1;
            end
            if (wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= wdata[15:0];
                wstrb_reg <= wstrb[1:0];
            end else if (bvalid_reg && bready) begin
                w_held_reg <= 1'b0;
                wready_reg <= 1'b1;
            end
            if (arvalid && arready_reg) begin
                ar_held_reg <= 1'b1;
                arready_reg <= 1'b0;
                araddr_reg <= araddr;
            end else if (rvalid_reg && rready) begin
                ar_held_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // Sequencer
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (go_rd) begin
                        state_reg <= ST_RD;
                    end else if (err_rd) begin
                        state_reg <= ST_RR;
                    end else if (go_wr) begin
                        state_reg <= ST_WR;
                    end else if (err_wr) begin
                        state_reg <= ST_BR;
                    end
                end
                ST_WR: if (link.ack) state_reg <= ST_BR;
                ST_RD: if (link.ack) state_reg <= ST_RR;
                ST_BR: if (bready) state_reg <= ST_IDLE;
                ST_RR: if (rready) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Device request, one cycle
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            wide_reg <= 1'b0;
            addr_reg <= 3'h0;
            dwdata_reg <= 16'h0000;
        end else begin
            req_reg <= go_rd || go_wr;
            if (go_rd) begin
                we_reg <= 1'b0;
                addr_reg <= r_idx;
            end else if (go_wr) begin
                we_reg <= 1'b1;
                wide_reg <= (w_idx != mdu_pkg::IDX_CTRL);
                addr_reg <= w_idx;
                dwdata_reg <= wdata_reg;
            end
        end
    end

    // Write response
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= mdu_pkg::RESP_OKAY;
        end else if (err_wr || (state_reg == ST_WR && link.ack)) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= err_wr ? mdu_pkg::RESP_SLVERR : mdu_pkg::RESP_OKAY;
        end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge link.aclk) begin
        if (!link.aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= mdu_pkg::RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else if (err_rd || (state_reg == ST_RD && link.ack)) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= err_rd ? mdu_pkg::RESP_SLVERR : mdu_pkg::RESP_OKAY;
            rdata_reg <= err_rd ? 32'h00000000 : {16'h0000, link.rdata};
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign arready = arready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign link.req = req_reg;
    assign link.we = we_reg;
    assign link.wide = wide_reg;
    assign link.addr = addr_reg;
    assign link.wdata = dwdata_reg;
endmodule

// File: logic/mdu_if.sv
`timescale 1ns/1ps
interface mdu_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic req;
    logic we;
    logic wide;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic div_busy;
    logic b_zero;

    modport device (
        input aclk, aresetn, req, we, wide, addr, wdata,
        output rdata, ack, div_busy, b_zero
    );
    modport host (
        input aclk, aresetn, rdata, ack, div_busy, b_zero,
        output req, we, wide, addr, wdata
    );
endinterface

// File: logic/mdu_pkg.sv
package mdu_pkg;
    localparam int DATA_W = 16;
    localparam int IDX_W = 3;
    localparam int DIV_STEPS = 32;
    localparam int STEP_W = 6;
    localparam int MIN_ADDR_W = 8;

    // Register index on the device port
    localparam logic [2:0] IDX_A_LOW = 3'h0;
    localparam logic [2:0] IDX_A_HIGH = 3'h1;
    localparam logic [2:0] IDX_B_LOW = 3'h2;
    localparam logic [2:0] IDX_B_HIGH = 3'h3;
    localparam logic [2:0] IDX_C_LOW = 3'h4;
    localparam logic [2:0] IDX_C_HIGH = 3'h5;
    localparam logic [2:0] IDX_CTRL = 3'h6;

    // Control register bit positions
    localparam int CTRL_DIV = 7;
    localparam int CTRL_ACC = 6;
    localparam int CTRL_SGN = 3;
    localparam int CTRL_OVF = 2;
    localparam int CTRL_NEG = 1;
    localparam int CTRL_START = 0;

    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // AXI4-Lite byte offsets
    localparam logic [7:0] OFF_A_LOW = 8'h00;
    localparam logic [7:0] OFF_A_HIGH = 8'h04;
    localparam logic [7:0] OFF_B_LOW = 8'h08;
    localparam logic [7:0] OFF_B_HIGH = 8'h0C;
    localparam logic [7:0] OFF_C_LOW = 8'h10;
    localparam logic [7:0] OFF_C_HIGH = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [2:0] off_to_idx(input logic [7:0] off);
        return off[4:2];
    endfunction

    function automatic logic off_valid(input logic [7:0] off);
        return (off[1:0] == 2'h0) && (off <= OFF_CTRL);
    endfunction
endpackage
